/* hw/csr_top.sv */
// The placing of the registers and the APB interface to the registers were decided locally.
`timescale 1ns/100ps
module csr_top (
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Comparators (polarity already applied)
  input wire logic cmp1_output,
  input wire logic cmp2_output,
  // Port direction, 0 means output
  input wire logic pin1_direction,
  input wire logic pin2_direction,
  // Pin paths
  output logic pin1_out,
  output logic pin1_oe_n,
  output logic pin2_out,
  output logic pin2_oe_n,
  output logic cmp1_on,
  output logic cmp2_on,
  output logic cmp1_polarity,
  output logic cmp2_polarity,
  output logic [2:0] cmp1_chan,
  output logic [2:0] cmp2_chan
);
  typedef struct packed {
    logic [7:0] cmp1;
    logic [7:0] cmp2;
    logic [7:0] latch;
    logic pset;
    logic prst;
    logic [31:0] rdata;
  } csr_state_s;

  csr_state_s st_ff;
  csr_state_s nxt_st;
  logic wr_acc;
  logic rd_acc;
  logic addr_ok;
  logic lat_set;
  logic lat_rst;
  logic lat_q;
  logic lat_qb;
  logic path1;
  logic path2;
  logic [7:0] rd_val;

  function automatic logic [7:0] merge(input logic [7:0] old,
      input logic [7:0] wd, input logic [7:0] msk);
    merge = (old & ~msk) | (wd & msk);
  endfunction : merge

  assign addr_ok = (paddr == csr_pkg::CSR_OFS_CMP1) ||
    (paddr == csr_pkg::CSR_OFS_CMP2) || (paddr == csr_pkg::CSR_OFS_LATCH);
  assign wr_acc = psel && penable && pwrite && pstrb[0] && addr_ok;
  assign rd_acc = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;
  assign prdata = st_ff.rdata;

  always_comb begin
    rd_val = 8'h00;
    if (paddr == csr_pkg::CSR_OFS_CMP1) begin
      rd_val = st_ff.cmp1;
      rd_val[csr_pkg::CSR_BIT_OUT] = cmp1_output;
    end else if (paddr == csr_pkg::CSR_OFS_CMP2) begin
      rd_val = st_ff.cmp2;
      rd_val[csr_pkg::CSR_BIT_OUT] = cmp2_output;
    end else if (paddr == csr_pkg::CSR_OFS_LATCH) begin
      rd_val = st_ff.latch;
    end
  end

  always_comb begin
    nxt_st = st_ff;
    // Pulses last one cycle, enough for the clockless latch to capture
    nxt_st.pset = 1'b0;
    nxt_st.prst = 1'b0;
    if (wr_acc) begin
      if (paddr == csr_pkg::CSR_OFS_CMP1) begin
        nxt_st.cmp1 = merge(st_ff.cmp1, pwdata[7:0],
          csr_pkg::CSR_CMP_WMASK);
      end else if (paddr == csr_pkg::CSR_OFS_CMP2) begin
        nxt_st.cmp2 = merge(st_ff.cmp2, pwdata[7:0],
          csr_pkg::CSR_CMP_WMASK);
      end else begin
        nxt_st.latch = merge(st_ff.latch, pwdata[7:0],
          csr_pkg::CSR_LATCH_WMASK);
        nxt_st.pset = pwdata[csr_pkg::CSR_BIT_PSET];
        nxt_st.prst = pwdata[csr_pkg::CSR_BIT_PRST];
      end
    end
    if (rd_acc) begin
      nxt_st.rdata = {24'h000000, rd_val};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nxt_st_reset: begin
        st_ff.cmp1 <= csr_pkg::CSR_RST_CMP;
        st_ff.cmp2 <= csr_pkg::CSR_RST_CMP;
        st_ff.latch <= csr_pkg::CSR_RST_LATCH;
        st_ff.pset <= 1'b0;
        st_ff.prst <= 1'b0;
        st_ff.rdata <= 32'h00000000;
      end
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Gating is independent of the comparator on bits
  assign lat_set = (cmp1_output && st_ff.latch[csr_pkg::CSR_BIT_SEN])
    || st_ff.pset;
  assign lat_rst = (cmp2_output && st_ff.latch[csr_pkg::CSR_BIT_REN])
    || st_ff.prst;

  csr_latch_core u_latch (
    .set_in(lat_set),
    .reset_in(lat_rst),
    .clear_n(presetn),
    .q(lat_q),
    .q_bar(lat_qb)
  );

  always_comb begin
    unique case (csr_pkg::csr_sel_e'(
        st_ff.latch[csr_pkg::CSR_BIT_SEL_HI:csr_pkg::CSR_BIT_SEL_LO]))
      csr_pkg::CSR_SEL_CMP_CMP: begin
        path1 = cmp1_output;
        path2 = cmp2_output;
      end
      csr_pkg::CSR_SEL_C1_QBAR: begin
        path1 = cmp1_output;
        path2 = lat_qb;
      end
      csr_pkg::CSR_SEL_C2_Q: begin
        path1 = lat_q;
        path2 = cmp2_output;
      end
      csr_pkg::CSR_SEL_Q_QBAR: begin
        path1 = lat_q;
        path2 = lat_qb;
      end
    endcase
  end

  // Pin driven only with direction output and output enable set
  assign pin1_oe_n = !(!pin1_direction &&
    st_ff.cmp1[csr_pkg::CSR_BIT_OE]);
  assign pin2_oe_n = !(!pin2_direction &&
    st_ff.cmp2[csr_pkg::CSR_BIT_OE]);
  assign pin1_out = pin1_oe_n ? 1'b0 : path1;
  assign pin2_out = pin2_oe_n ? 1'b0 : path2;
  assign cmp1_on = st_ff.cmp1[csr_pkg::CSR_BIT_ON];
  assign cmp2_on = st_ff.cmp2[csr_pkg::CSR_BIT_ON];
  assign cmp1_polarity = st_ff.cmp1[csr_pkg::CSR_BIT_POL];
  assign cmp2_polarity = st_ff.cmp2[csr_pkg::CSR_BIT_POL];
  assign cmp1_chan = st_ff.cmp1[2:0];
  assign cmp2_chan = st_ff.cmp2[2:0];
endmodule : csr_top

/* common/csr_pkg.sv */
// Contract
// - Latch sets on gated comparator 1 output or a pulse-set write of one.
// - Latch resets on gated comparator 2 output or a pulse-reset write of one.
// - Latch inputs are active high and act without any clock.
// - Set and reset together give the reset state.
// - Pulse-set and pulse-reset bits clear themselves after a write of one.
// - Output-select field picks what the two comparator pin paths carry.
// - After reset the output select returns to both raw comparator outputs.
// - A pin gets the signal only when its direction is output and enabled.
// - Latch and output select work whether or not comparators are on.
// - Latch control: select 7:6, enables 5:4, pulses 3:2, bits 1:0 zero.
// - Comparator control: on 7, output 6, enable 5, polarity 4, bit 3 zero.
package csr_pkg;
  localparam logic [11:0] CSR_OFS_CMP1 = 12'h000;
  localparam logic [11:0] CSR_OFS_CMP2 = 12'h004;
  localparam logic [11:0] CSR_OFS_LATCH = 12'h008;
  localparam logic [7:0] CSR_RST_CMP = 8'h00;
  localparam logic [7:0] CSR_RST_LATCH = 8'h00;
  localparam int CSR_BIT_ON = 7;
  localparam int CSR_BIT_OUT = 6;
  localparam int CSR_BIT_OE = 5;
  localparam int CSR_BIT_POL = 4;
  localparam int CSR_BIT_SEL_HI = 7;
  localparam int CSR_BIT_SEL_LO = 6;
  localparam int CSR_BIT_SEN = 5;
  localparam int CSR_BIT_REN = 4;
  localparam int CSR_BIT_PSET = 3;
  localparam int CSR_BIT_PRST = 2;
  // Writable masks: comparator bit 6 and 3 are not stored
  localparam logic [7:0] CSR_CMP_WMASK = 8'hb7;
  localparam logic [7:0] CSR_LATCH_WMASK = 8'hf0;
  typedef enum logic [1:0] {
    CSR_SEL_CMP_CMP,
    CSR_SEL_C1_QBAR,
    CSR_SEL_C2_Q,
    CSR_SEL_Q_QBAR
  } csr_sel_e;
endpackage : csr_pkg

/* hw/csr_latch_core.sv */
`timescale 1ns/100ps
// Clockless reset-dominant SR latch, modelled as a level-sensitive always_latch block
module csr_latch_core (
  // Latch inputs
  input wire logic set_in,
  input wire logic reset_in,
  input wire logic clear_n,
  // Latch outputs
  output logic q,
  output logic q_bar
);
  always_latch begin
    if (!clear_n) begin
      q <= 1'b0;
    end else if (reset_in) begin
      q <= 1'b0;
    end else if (set_in) begin
      q <= 1'b1;
    end
  end
  assign q_bar = ~q;
endmodule : csr_latch_core

/* tb/csr_cmp_model.sv */
`timescale 1ns/100ps
module csr_cmp_model #(parameter int DLY = 2) (
  input wire logic pclk,
  input wire logic [1:0] want,
  output logic [1:0] cmp
);
  // Settling lag of an analog comparator
  logic [1:0] pipe [DLY];
  always_ff @(posedge pclk) begin
    pipe[0] <= want;
    for (int i = 1; i < DLY; i++) pipe[i] <= pipe[i - 1];
  end
  assign cmp = pipe[DLY - 1];
endmodule : csr_cmp_model

/* tb/csr_properties.sv */
`timescale 1ns/100ps
module csr_properties (
  input wire logic pclk, presetn, psel, penable, pwrite, pslverr,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata, prdata,
  input wire logic [3:0] pstrb,
  input wire logic cmp1_output, cmp2_output, pin1_direction, pin2_direction,
  input wire logic pin1_out, pin1_oe_n, pin2_out, pin2_oe_n
);
  logic [1:0] sel_ff;
  logic oe1_ff, oe2_ff;
  wire acc = psel & penable;
  wire rd = acc & !pwrite;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) {sel_ff, oe1_ff, oe2_ff} <= '0;
    else if (acc & pwrite & pstrb[0]) begin
      if (paddr == 12'h0) oe1_ff <= pwdata[5];
      if (paddr == 12'h4) oe2_ff <= pwdata[5];
      if (paddr == 12'h8) sel_ff <= pwdata[7:6];
    end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_ERR: assert property (acc && !(paddr inside {0, 4, 8}) |-> pslverr)
    else $error("no pslverr");
  AST_IN1: assert property (pin1_direction |-> pin1_oe_n && !pin1_out)
    else $error("pin1 driven");
  AST_EN1: assert property (!pin1_direction && oe1_ff |-> !pin1_oe_n)
    else $error("pin1 idle");
  AST_EN2: assert property ((pin2_direction || !oe2_ff) == pin2_oe_n)
    else $error("pin2 oe");
  AST_P1: assert property (!pin1_oe_n && !sel_ff[1]
    |-> pin1_out == cmp1_output) else $error("pin1 not cmp1");
  AST_P2: assert property (!pin2_oe_n && !sel_ff[0]
    |-> pin2_out == cmp2_output) else $error("pin2 not cmp2");
  AST_QQ: assert property (sel_ff == 2'h3 && !pin1_oe_n && !pin2_oe_n
    |-> pin1_out != pin2_out) else $error("q equals q_bar");
  AST_PLS: assert property (rd && paddr == 12'h8 |=> prdata[3:0] == 4'h0)
    else $error("pulse bits read back");
  AST_CMP: assert property (rd && paddr == 12'h0 |=> prdata[3] == 1'b0)
    else $error("bit 3 set");
  cover property (sel_ff == 2'h3 && !pin1_oe_n && pin1_out);
  cover property (acc && pslverr);
  cover property (cmp1_output && cmp2_output && !pin1_oe_n);
endmodule : csr_properties
bind csr_top csr_properties i_props (.*);

/* tb/tb_comparator_sr_latch.sv */
`timescale 1ns/100ps
module tb_comparator_sr_latch;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
  logic d1 = 1, d2 = 1, pready, pslverr, p1, o1, p2, o2;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic [1:0] want = '0, cmp;
  logic on1, on2, po1, po2;
  logic [2:0] ch1, ch2;
  int failures = 0, comparisons = 0, cyc = 0;
  csr_cmp_model i_cmp (.pclk, .want, .cmp);
  csr_top i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb(4'hf), .prdata, .pready, .pslverr, .cmp1_output(cmp[0]),
    .cmp2_output(cmp[1]), .pin1_direction(d1), .pin2_direction(d2),
    .pin1_out(p1), .pin1_oe_n(o1), .pin2_out(p2), .pin2_oe_n(o2),
    .cmp1_on(on1), .cmp2_on(on2), .cmp1_polarity(po1), .cmp2_polarity(po2),
    .cmp1_chan(ch1), .cmp2_chan(ch2));
  initial forever #5 pclk = ~pclk;
  task automatic complete_run();
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : complete_run
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 3000) begin
      failures++;
      complete_run();
    end
  end
  task automatic chk(string n, logic [31:0] e, logic [31:0] s);
    comparisons++;
    if (s !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      err = pslverr;
    end while (pready !== 1'b1);
    {psel, penable} <= 2'b00;
    #1;
  endtask : apb
  // Waits on the comparator itself so the model may lag any amount
  task automatic set_cmp(logic [1:0] v);
    @(posedge pclk);
    want <= v;
    wait (cmp === v);
    #1;
  endtask : set_cmp
  task automatic t_reset();
    for (int a = 0; a < 12; a += 4) begin
      apb(0, 12'(a), 0);
      chk("reset value", 0, prdata);
    end
  endtask : t_reset
  task automatic t_mux();
    apb(1, 12'h0, 32'h20);
    apb(1, 12'h4, 32'h20);
    chk("pin1_oe_n", 1, o1);
    @(posedge pclk);
    {d1, d2} <= 2'b00;
    set_cmp(2'b10);
    chk("default pins", 2'b01, {p1, p2});
    set_cmp(2'b00);
    for (int i = 0; i < 8; i++) begin
      apb(1, 12'h8, 32'(i % 4 * 64 + i / 4 * 4 + 4));
      chk("pin pair", {i[1] & i[2], i[0] & !i[2]}, {p1, p2});
    end
  endtask : t_mux
  task automatic t_latch();
    apb(0, 12'h8, 0);
    chk("latch_control", 32'hc0, prdata);
    set_cmp(2'b10);
    chk("q held", 1, p1);
    set_cmp(2'b00);
    apb(1, 12'h8, 32'hd0);
    set_cmp(2'b10);
    chk("q reset", 0, p1);
    set_cmp(2'b01);
    chk("q still reset", 0, p1);
    apb(1, 12'h8, 32'hf0);
    chk("q set", 1, p1);
    set_cmp(2'b11);
    chk("both high", 2'b01, {p1, p2});
  endtask : t_latch
  task automatic t_err();
    apb(1, 12'hffc, 32'hff);
    chk("pslverr", 1, err);
    apb(0, 12'h8, 0);
    chk("latch_control", 32'hf0, prdata);
    apb(1, 12'h0, 32'hff);
    apb(0, 12'h0, 0);
    chk("comparator1_control", 32'hf7, prdata);
    chk("cmp1 fields", 5'h1f, {on1, po1, ch1});
    chk("cmp2 fields", 5'h00, {on2, po2, ch2});
  endtask : t_err
  // Reset in mid-run must drop the select back to raw comparators
  task automatic t_rst2();
    apb(1, 12'h8, 32'hc8);
    @(posedge pclk);
    presetn <= 0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    apb(0, 12'h8, 0);
    chk("latch_control after reset", 0, prdata);
    apb(1, 12'h0, 32'h20);
    apb(1, 12'h4, 32'h20);
    chk("pins after reset", 2'b11, {p1, p2});
  endtask : t_rst2
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1;
    t_reset();
    t_mux();
    t_latch();
    t_err();
    t_rst2();
    complete_run();
  end
endmodule : tb_comparator_sr_latch
